/* rtl/period_measure_pkg.sv */
// Notes on behaviour
// - period counter counts selected reference edges between two gate rising edges.
// - starting a measurement presets the counter output low.
// - counter waits idle for the first gate rising edge, then counts.
// - second gate rising edge copies the count into the hold register.
// - only gate rising edges matter; duty cycle has no effect.
// - count reaching 65535 before the second edge drives the output high.
// - reference clock chosen by codes 11 to 15, five decade-spaced sources.
// - frequency output equals chosen source divided by a 1 to 16 divider.
// - only the first chip drives its frequency output to the header.
// - separate comparator enables for counter 1 and counter 2.
// - enabled comparator output is high exactly while count equals alarm value.
// - time-of-day prescale of 5, 6 or 10 gives tenth-second steps.
package period_measure_pkg;

   // ------------------------------------------------------------------
   // register map
   // ------------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_HOLD = 8'h08;
   localparam logic [7:0] ADDR_MASTER = 8'h0c;
   localparam logic [7:0] ADDR_ALARM1 = 8'h10;
   localparam logic [7:0] ADDR_ALARM2 = 8'h14;
   localparam logic [7:0] ADDR_COUNT1 = 8'h18;
   localparam logic [7:0] ADDR_COUNT2 = 8'h1c;
   localparam logic [7:0] ADDR_TOD = 8'h20;

   // ------------------------------------------------------------------
   // field positions and reset values
   // ------------------------------------------------------------------
   localparam int CTRL_SEL_LSB = 0;
   localparam int CTRL_START_BIT = 4;
   localparam int STAT_WAIT_BIT = 0;
   localparam int STAT_COUNT_BIT = 1;
   localparam int STAT_DONE_BIT = 2;
   localparam int STAT_COUNT_OVERFLOW_ERROR_BIT = 3;
   localparam int MASTER_DIV_LSB = 0;
   localparam int MASTER_SRC_LSB = 4;
   localparam int MASTER_CMP1_BIT = 8;
   localparam int MASTER_CMP2_BIT = 9;
   localparam int MASTER_TOD_LSB = 10;
   localparam logic [3:0] REF_SEL_RST = 4'hb;
   localparam logic [3:0] FOUT_SRC_RST = 4'hb;
   localparam logic [3:0] FOUT_DIV_RST = 4'h0;
   localparam logic [1:0] TOD_MODE_RST = 2'h0;

   // ------------------------------------------------------------------
   // sources and counts
   // ------------------------------------------------------------------
   localparam int NUM_REFS = 5;
   localparam logic [3:0] REF_CODE_FIRST = 4'hb;
   localparam logic [3:0] REF_CODE_LAST = 4'hf;
   localparam logic [3:0] DECADE_LAST = 4'h9;
   localparam int CNT_W = 16;
   localparam logic [15:0] CNT_MAX = 16'hffff;
   localparam logic [3:0] TOD_DIV_50HZ = 4'h5;
   localparam logic [3:0] TOD_DIV_60HZ = 4'h6;
   localparam logic [3:0] TOD_DIV_100HZ = 4'ha;

   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b000,
      ST_WAIT = 3'b001,
      ST_COUNT = 3'b010,
      ST_DONE = 3'b011,
      ST_OVF = 3'b100
   } meas_e;

   // raw asynchronous pins
   typedef struct packed
   {
      logic gate;
      logic osc;
      logic tot1;
      logic tot2;
      logic tod;
   } pins_s;

   // comparator and time-of-day outputs
   typedef struct packed
   {
      logic cmp1_out;
      logic cmp2_out;
      logic tod_tick;
   } alarm_out_s;

endpackage

/* rtl/decade_prescaler.sv */
`timescale 1ns/10ps
module decade_prescaler
#(
   parameter int STAGES = 5
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic osc_edge,
   output logic [STAGES-1:0] ticks
);
   import period_measure_pkg::*;

   typedef struct packed
   {
      logic [STAGES-1:1][3:0] cnt;
   } pre_state_s;

   pre_state_s pre_ff;
   pre_state_s nxt_pre;

   // ------------------------------------------------------------------
   // tick chain, each stage one tenth of the one before
   // ------------------------------------------------------------------
   assign ticks[0] = osc_edge;

   for (genvar i = 1; i < STAGES; i++)
   begin : g_stage
      assign ticks[i] = ticks[i-1] && (pre_ff.cnt[i] == DECADE_LAST);
   end

   always_comb
   begin
      nxt_pre = pre_ff;
      for (int i = 1; i < STAGES; i++)
      begin
         if (ticks[i-1])
         begin
            nxt_pre.cnt[i] = (pre_ff.cnt[i] == DECADE_LAST) ? 4'h0 : pre_ff.cnt[i] + 4'h1;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         pre_ff <= '0;
      end
      else
      begin
         pre_ff <= nxt_pre;
      end
   end

endmodule

/* rtl/period_measure_counter_config.sv */
// Design decisions made here: the AHB-Lite slave port and the register offsets.
`timescale 1ns/10ps
module period_measure_counter_config
#(
   parameter int CHIP_INDEX = 1
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire period_measure_pkg::pins_s pins,
   output logic period_out,
   output logic fout_pin,
   output logic fout_pin_en,
   output logic fout_tick,
   output period_measure_pkg::alarm_out_s alarms
);
   import period_measure_pkg::*;

   typedef struct packed
   {
      pins_s sync1;
      pins_s sync2;
      pins_s prev;
      meas_e state;
      logic [CNT_W-1:0] cnt;
      logic [CNT_W-1:0] hold;
      logic period_out;
      logic done;
      logic [3:0] ref_sel;
      logic [3:0] fout_src;
      logic [3:0] fout_div;
      logic [3:0] fout_cnt;
      logic fout;
      logic cmp1_on;
      logic cmp2_on;
      logic [1:0] tod_mode;
      logic [CNT_W-1:0] alarm1;
      logic [CNT_W-1:0] alarm2;
      logic [CNT_W-1:0] count1;
      logic [CNT_W-1:0] count2;
      logic cmp1;
      logic cmp2;
      logic [3:0] tod_pre;
      logic [31:0] tod_tenths;
      logic tod_tick;
      logic ap_valid;
      logic ap_write;
      logic [7:0] ap_addr;
      logic [31:0] rdata;
   } meas_state_s;

   meas_state_s st_ff;
   meas_state_s nxt_st;
   logic [NUM_REFS-1:0] ref_ticks;
   logic osc_rise;
   logic gate_rise;
   logic tot1_rise;
   logic tot2_rise;
   logic tod_rise;
   logic ref_tick;
   logic src_tick;
   logic wr_en;
   logic start_wr;

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   // codes outside 11..15 select nothing, so an idle source never counts
   function automatic logic pick_tick(input logic [3:0] code, input logic [NUM_REFS-1:0] t);
      logic hit;
      hit = 1'b0;
      if (code >= REF_CODE_FIRST && code <= REF_CODE_LAST)
      begin
         hit = t[3'(code - REF_CODE_FIRST)];
      end
      return hit;
   endfunction

   function automatic logic [3:0] tod_limit(input logic [1:0] mode);
      logic [3:0] lim;
      unique case (mode)
         2'h0: lim = TOD_DIV_50HZ;
         2'h1: lim = TOD_DIV_60HZ;
         default: lim = TOD_DIV_100HZ;
      endcase
      return lim;
   endfunction

   function automatic logic [31:0] read_word(input meas_state_s v, input logic [7:0] addr);
      logic [31:0] w;
      w = 32'h0000_0000;
      case (addr)
         ADDR_CTRL: w[CTRL_SEL_LSB +: 4] = v.ref_sel;
         ADDR_STATUS:
         begin
            w[STAT_WAIT_BIT] = (v.state == ST_WAIT);
            w[STAT_COUNT_BIT] = (v.state == ST_COUNT);
            w[STAT_DONE_BIT] = v.done;
            w[STAT_COUNT_OVERFLOW_ERROR_BIT] = (v.state == ST_OVF);
         end
         ADDR_HOLD: w[CNT_W-1:0] = v.hold;
         ADDR_MASTER:
         begin
            w[MASTER_DIV_LSB +: 4] = v.fout_div;
            w[MASTER_SRC_LSB +: 4] = v.fout_src;
            w[MASTER_CMP1_BIT] = v.cmp1_on;
            w[MASTER_CMP2_BIT] = v.cmp2_on;
            w[MASTER_TOD_LSB +: 2] = v.tod_mode;
         end
         ADDR_ALARM1: w[CNT_W-1:0] = v.alarm1;
         ADDR_ALARM2: w[CNT_W-1:0] = v.alarm2;
         ADDR_COUNT1: w[CNT_W-1:0] = v.count1;
         ADDR_COUNT2: w[CNT_W-1:0] = v.count2;
         ADDR_TOD: w = v.tod_tenths;
         default: w = 32'h0000_0000;
      endcase
      return w;
   endfunction

   // ------------------------------------------------------------------
   // reference sources
   // ------------------------------------------------------------------
   assign osc_rise = st_ff.sync2.osc && !st_ff.prev.osc;

   decade_prescaler #(.STAGES(NUM_REFS)) u_prescaler
   (
      .clk(clk),
      .rst_n(rst_n),
      .osc_edge(osc_rise),
      .ticks(ref_ticks)
   );

   // ------------------------------------------------------------------
   // edge detection on synchronised pins
   // ------------------------------------------------------------------
   // falling edges are never looked at, so duty cycle cannot matter
   assign gate_rise = st_ff.sync2.gate && !st_ff.prev.gate;
   assign tot1_rise = st_ff.sync2.tot1 && !st_ff.prev.tot1;
   assign tot2_rise = st_ff.sync2.tot2 && !st_ff.prev.tot2;
   assign tod_rise = st_ff.sync2.tod && !st_ff.prev.tod;
   assign ref_tick = pick_tick(st_ff.ref_sel, ref_ticks);
   assign src_tick = pick_tick(st_ff.fout_src, ref_ticks);
   assign wr_en = st_ff.ap_valid && st_ff.ap_write;
   assign start_wr = wr_en && (st_ff.ap_addr == ADDR_CTRL) && hwdata[CTRL_START_BIT];

   // ------------------------------------------------------------------
   // next state
   // ------------------------------------------------------------------
   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.sync1 = pins;
      nxt_st.sync2 = st_ff.sync1;
      nxt_st.prev = st_ff.sync2;
      nxt_st.fout = 1'b0;
      nxt_st.tod_tick = 1'b0;

      // register writes in the data phase
      if (wr_en)
      begin
         case (st_ff.ap_addr)
            ADDR_CTRL: nxt_st.ref_sel = hwdata[CTRL_SEL_LSB +: 4];
            ADDR_MASTER:
            begin
               nxt_st.fout_div = hwdata[MASTER_DIV_LSB +: 4];
               nxt_st.fout_src = hwdata[MASTER_SRC_LSB +: 4];
               nxt_st.cmp1_on = hwdata[MASTER_CMP1_BIT];
               nxt_st.cmp2_on = hwdata[MASTER_CMP2_BIT];
               nxt_st.tod_mode = hwdata[MASTER_TOD_LSB +: 2];
            end
            ADDR_ALARM1: nxt_st.alarm1 = hwdata[CNT_W-1:0];
            ADDR_ALARM2: nxt_st.alarm2 = hwdata[CNT_W-1:0];
            ADDR_COUNT1: nxt_st.count1 = hwdata[CNT_W-1:0];
            ADDR_COUNT2: nxt_st.count2 = hwdata[CNT_W-1:0];
            default: nxt_st.done = st_ff.done;
         endcase
      end

      // period measurement
      if (start_wr)
      begin
         nxt_st.period_out = 1'b0;
         nxt_st.cnt = '0;
         nxt_st.done = 1'b0;
         nxt_st.state = ST_WAIT;
      end
      else
      begin
         unique case (st_ff.state)
            ST_IDLE, ST_DONE, ST_OVF: nxt_st.state = st_ff.state;
            ST_WAIT:
            begin
               if (gate_rise)
               begin
                  nxt_st.state = ST_COUNT;
               end
            end
            ST_COUNT:
            begin
               if (gate_rise)
               begin
                  nxt_st.hold = st_ff.cnt;
                  nxt_st.done = 1'b1;
                  nxt_st.state = ST_DONE;
               end
               else if (ref_tick)
               begin
                  nxt_st.cnt = st_ff.cnt + 16'h0001;
                  if (st_ff.cnt == CNT_MAX - 16'h0001)
                  begin
                     nxt_st.period_out = 1'b1;
                     nxt_st.state = ST_OVF;
                  end
               end
            end
            default: nxt_st.state = ST_IDLE;
         endcase
      end

      // frequency output generator, divider field holds divide-by minus one
      if (src_tick)
      begin
         if (st_ff.fout_cnt == st_ff.fout_div)
         begin
            nxt_st.fout_cnt = 4'h0;
            nxt_st.fout = 1'b1;
         end
         else
         begin
            nxt_st.fout_cnt = st_ff.fout_cnt + 4'h1;
         end
      end

      // totalizers with alarm comparators
      if (tot1_rise)
      begin
         nxt_st.count1 = nxt_st.count1 + 16'h0001;
      end
      if (tot2_rise)
      begin
         nxt_st.count2 = nxt_st.count2 + 16'h0001;
      end
      nxt_st.cmp1 = nxt_st.cmp1_on && (nxt_st.count1 == nxt_st.alarm1);
      nxt_st.cmp2 = nxt_st.cmp2_on && (nxt_st.count2 == nxt_st.alarm2);

      // time of day, a prescale change mid-count may stretch one step
      if (tod_rise)
      begin
         if (st_ff.tod_pre >= tod_limit(st_ff.tod_mode) - 4'h1)
         begin
            nxt_st.tod_pre = 4'h0;
            nxt_st.tod_tenths = st_ff.tod_tenths + 32'h0000_0001;
            nxt_st.tod_tick = 1'b1;
         end
         else
         begin
            nxt_st.tod_pre = st_ff.tod_pre + 4'h1;
         end
      end

      // address phase capture; read data sees this cycle's write
      nxt_st.ap_valid = hsel && htrans[1] && hready;
      nxt_st.ap_write = hwrite;
      nxt_st.ap_addr = haddr[7:0];
      if (hsel && htrans[1] && hready && !hwrite)
      begin
         nxt_st.rdata = read_word(nxt_st, haddr[7:0]);
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         st_ff <= '0;
         st_ff.ref_sel <= REF_SEL_RST;
         st_ff.fout_src <= FOUT_SRC_RST;
         st_ff.fout_div <= FOUT_DIV_RST;
         st_ff.tod_mode <= TOD_MODE_RST;
         st_ff.state <= ST_IDLE;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   // ------------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------------
   assign hrdata = st_ff.rdata;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign period_out = st_ff.period_out;
   assign fout_tick = st_ff.fout;
   // second chip keeps its frequency output internal
   assign fout_pin = (CHIP_INDEX == 1) ? st_ff.fout : 1'b0;
   assign fout_pin_en = (CHIP_INDEX == 1);
   assign alarms = '{cmp1_out: st_ff.cmp1, cmp2_out: st_ff.cmp2, tod_tick: st_ff.tod_tick};

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   preset_low_a: assert property (start_wr |=> !period_out && st_ff.state == ST_WAIT)
      else $error("start did not preset output low");

   wait_idle_a: assert property (st_ff.state == ST_WAIT && !gate_rise && !start_wr
      |=> st_ff.state == ST_WAIT && st_ff.cnt == $past(st_ff.cnt))
      else $error("counter left wait without a gate edge");

   count_step_a: assert property (st_ff.state == ST_COUNT && ref_tick && !gate_rise
      && !start_wr |=> st_ff.cnt == $past(st_ff.cnt) + 16'h0001)
      else $error("reference edge not counted");

   hold_latch_a: assert property (st_ff.state == ST_COUNT && gate_rise && !start_wr
      |=> st_ff.hold == $past(st_ff.cnt) && st_ff.done)
      else $error("second gate edge did not latch hold");

   hold_keep_a: assert property (st_ff.state != ST_COUNT |=> $stable(st_ff.hold))
      else $error("hold changed without a latch");

   ovf_flag_a: assert property (st_ff.state == ST_COUNT && ref_tick && !gate_rise
      && !start_wr && st_ff.cnt == 16'hfffe |=> period_out && st_ff.state == ST_OVF)
      else $error("overflow not signalled at full count");

   ovf_stick_a: assert property (period_out && !start_wr |=> period_out)
      else $error("overflow output dropped without start");

   edge_only_a: assert property (st_ff.state == ST_WAIT && !start_wr
      && $fell(st_ff.sync2.gate) |=> st_ff.state == ST_WAIT)
      else $error("falling gate edge started counting");

   cmp_match_a: assert property (alarms.cmp1_out == (st_ff.cmp1_on
      && st_ff.count1 == st_ff.alarm1))
      else $error("comparator 1 output disagrees with count");

   fout_rate_a: assert property (fout_tick |-> $past(src_tick)
      && $past(st_ff.fout_cnt) == $past(st_ff.fout_div))
      else $error("frequency output pulse off divider");

   tod_step_a: assert property (alarms.tod_tick |-> $past(tod_rise)
      && $past(st_ff.tod_pre) + 4'h1 >= tod_limit($past(st_ff.tod_mode)))
      else $error("time of day stepped early");

endmodule

/* tb/signal_source.sv */
`timescale 1ns/10ps
module signal_source
(
   input wire logic clk,
   input wire logic gate_run,
   input wire logic [31:0] gate_period,
   input wire logic [31:0] gate_high,
   input wire logic [1:0] tot_lvl,
   input wire logic tod_run,
   output period_measure_pkg::pins_s pins
);
   import period_measure_pkg::*;
   logic [31:0] ph_ff = 32'h0000_0000;
   always_ff @(posedge clk)
   begin
      ph_ff <= ph_ff + 32'h0000_0001;
   end
   // -----------------------------------------------------------------
   // pins
   // -----------------------------------------------------------------
   // osc rises on odd phases, gate only on even ones: never in one cycle
   always_comb
   begin
      pins.osc = ph_ff[0];
      pins.gate = gate_run && ((ph_ff % gate_period) < gate_high);
      pins.tot1 = tot_lvl[0];
      pins.tot2 = tot_lvl[1];
      pins.tod = tod_run && ph_ff[3];
   end
endmodule

/* tb/period_measure_counter_config_bench.sv */
`timescale 1ns/10ps
module period_measure_counter_config_bench;
   import period_measure_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'b00;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'b010;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   pins_s pins;
   logic period_out;
   logic fout_pin;
   logic fout_pin_en;
   logic fout_tick;
   alarm_out_s alarms;
   logic gate_run = 1'b0;
   logic [31:0] gate_period = 32'h0000_0002;
   logic [31:0] gate_high = 32'h0000_0001;
   logic [1:0] tot_lvl = 2'b00;
   logic tod_run = 1'b0;
   int error_cnt = 0;
   int n_tests = 0;
   logic [31:0] q;
   int n;

   period_measure_counter_config dut_u (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pins(pins),
      .period_out(period_out), .fout_pin(fout_pin), .fout_pin_en(fout_pin_en),
      .fout_tick(fout_tick), .alarms(alarms));
   signal_source src_u (.clk(clk), .gate_run(gate_run), .gate_period(gate_period),
      .gate_high(gate_high), .tot_lvl(tot_lvl), .tod_run(tod_run), .pins(pins));

   initial
   begin
      forever #50 clk = ~clk;
   end

   // -----------------------------------------------------------------
   // shared tasks
   // -----------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wait_rdy();
      @(posedge clk);
      while (hreadyout !== 1'b1)
      begin
         @(posedge clk);
      end
   endtask

   // single word transfer; read data taken at the edge ending the data phase
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      hwrite <= w;
      htrans <= 2'b10;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      wait_rdy();
      q = hrdata;
   endtask

   task automatic tot_pulse();
      tot_lvl <= 2'b11;
      repeat (5) @(posedge clk);
      tot_lvl <= 2'b00;
      repeat (6) @(posedge clk);
   endtask

   // cycles between two pulses of fout_tick (sel 0) or tod_tick (sel 1)
   task automatic gap(input logic sel);
      int i;
      for (i = 0; i < 2000 && (sel ? alarms.tod_tick : fout_tick) !== 1'b1; i++) @(posedge clk);
      @(posedge clk);
      n = 1;
      while ((sel ? alarms.tod_tick : fout_tick) !== 1'b1 && n < 2000)
      begin
         @(posedge clk);
         n++;
      end
   endtask

   // -----------------------------------------------------------------
   // scenarios
   // -----------------------------------------------------------------
   task automatic reg_reset();
      logic [7:0] a[6];
      logic [31:0] e[6];
      a = '{ADDR_CTRL, ADDR_MASTER, ADDR_STATUS, ADDR_HOLD, ADDR_COUNT1, 8'h24};
      e = '{32'h0000_000b, 32'h0000_00b0, 0, 0, 0, 0};
      foreach (a[i])
      begin
         bus(1'b0, a[i], 32'h0000_0000);
         check("reset reg", q, e[i]);
      end
      bus(1'b1, ADDR_HOLD, 32'h0000_1234);
      bus(1'b0, ADDR_HOLD, 32'h0000_0000);
      check("hold read only", q, 32'h0000_0000);
      check("hresp", {31'h0, hresp}, 32'h0000_0000);
      check("fout enable", {31'h0, fout_pin_en}, 32'h0000_0001);
   endtask

   // gate period is m reference periods of t cycles
   task automatic measure(input logic [3:0] code, input int t, input int m, input int hi);
      int i;
      gate_period <= t * m;
      gate_high <= hi;
      gate_run <= 1'b1;
      repeat (t * m + 8) @(posedge clk);
      bus(1'b1, ADDR_CTRL, {27'h000_0000, 1'b1, code});
      @(posedge clk);
      check("preset low", {31'h0, period_out}, 32'h0000_0000);
      for (i = 0; i < 40000; i++)
      begin
         bus(1'b0, ADDR_STATUS, 32'h0000_0000);
         if (q[STAT_DONE_BIT] === 1'b1)
            break;
      end
      check("done", q, 32'h0000_0004);
      bus(1'b0, ADDR_HOLD, 32'h0000_0000);
      check("hold", q, m);
   endtask

   task automatic idle_wait();
      gate_run <= 1'b0;
      bus(1'b1, ADDR_CTRL, 32'h0000_001b);
      repeat (40) @(posedge clk);
      bus(1'b0, ADDR_STATUS, 32'h0000_0000);
      check("waiting", q, 32'h0000_0001);
   endtask

   task automatic comparators();
      bus(1'b1, ADDR_ALARM1, 32'h0000_0005);
      bus(1'b1, ADDR_ALARM2, 32'h0000_0005);
      bus(1'b1, ADDR_COUNT1, 32'h0000_0004);
      bus(1'b1, ADDR_COUNT2, 32'h0000_0004);
      bus(1'b1, ADDR_MASTER, 32'h0000_00b0 | (32'h0000_0001 << MASTER_CMP1_BIT));
      tot_pulse();
      check("cmp1 equal", {31'h0, alarms.cmp1_out}, 32'h0000_0001);
      check("cmp2 off", {31'h0, alarms.cmp2_out}, 32'h0000_0000);
      tot_pulse();
      check("cmp1 past", {31'h0, alarms.cmp1_out}, 32'h0000_0000);
      bus(1'b1, ADDR_MASTER, 32'h0000_00b0 | (32'h0000_0001 << MASTER_CMP2_BIT));
      bus(1'b1, ADDR_COUNT2, 32'h0000_0005);
      repeat (3) @(posedge clk);
      check("cmp2 equal", {31'h0, alarms.cmp2_out}, 32'h0000_0001);
      check("cmp1 off", {31'h0, alarms.cmp1_out}, 32'h0000_0000);
   endtask

   task automatic fout_div(input int d);
      bus(1'b1, ADDR_MASTER, 32'h0000_00b0 | (d - 1));
      gap(1'b0);
      gap(1'b0);
      check("fout gap", n, 2 * d);
      check("fout pin", {31'h0, fout_pin}, 32'h0000_0001);
   endtask

   task automatic tod_prescale(input int mode, input int div);
      bus(1'b1, ADDR_MASTER, 32'h0000_00b0 | (mode << MASTER_TOD_LSB));
      gap(1'b1);
      gap(1'b1);
      check("tod gap", n, 16 * div);
   endtask

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial
   begin
      repeat (95000) @(posedge clk);
      error_cnt++;
      end_of_test();
   end

   initial
   begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      reg_reset();
      bus(1'b1, ADDR_MASTER, 32'h0000_00b0);
      idle_wait();
      measure(4'hb, 2, 50, 50);
      measure(4'hb, 2, 50, 2);
      measure(4'hb, 2, 50, 98);
      repeat (300) @(posedge clk);
      bus(1'b0, ADDR_HOLD, 32'h0000_0000);
      check("hold kept", q, 32'h0000_0032);
      measure(4'hc, 20, 5, 50);
      measure(4'hd, 200, 3, 300);
      measure(4'he, 2000, 2, 2000);
      measure(4'hf, 20000, 1, 10000);
      gate_run <= 1'b0;
      comparators();
      fout_div(1);
      fout_div(16);
      tod_run <= 1'b1;
      tod_prescale(0, 5);
      tod_prescale(1, 6);
      tod_prescale(2, 10);
      end_of_test();
   end
endmodule
